//--- hw/bmd_pkg.sv
//----------------------------------------------------------------------
// Purpose: Constants for the byte-move decode and execute block
// Assumes: 8-bit data, 256-byte internal data space
// Notes:   Opcodes, address of the working register, lengths, timing
//----------------------------------------------------------------------
package bmd_pkg;

   // -------------------------------------------------------------
   // Opcode patterns
   // -------------------------------------------------------------
   localparam logic [7:0] OP_A_DIR = 8'he5; // Working reg from direct
   localparam logic [7:0] OP_A_IMM = 8'h74; // Working reg from immediate
   localparam logic [7:0] OP_DIR_A = 8'hf5; // Direct from working reg
   localparam logic [7:0] OP_DIR_DIR = 8'h85; // Direct to direct
   localparam logic [7:0] OP_DIR_IMM = 8'h75; // Direct from immediate
   localparam logic [4:0] OP_A_BANK = 5'h1d; // 11101rrr
   localparam logic [4:0] OP_BANK_A = 5'h1f; // 11111rrr
   localparam logic [4:0] OP_BANK_DIR = 5'h15; // 10101rrr
   localparam logic [4:0] OP_BANK_IMM = 5'h0f; // 01111rrr
   localparam logic [4:0] OP_DIR_BANK = 5'h11; // 10001rrr
   localparam logic [6:0] OP_A_IND = 7'h73; // 1110011i
   localparam logic [6:0] OP_DIR_IND = 7'h43; // 1000011i

   // -------------------------------------------------------------
   // Address map and reset values
   // -------------------------------------------------------------
   localparam logic [7:0] ACC_DIR_ADDR = 8'he0; // Working reg direct addr
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;

   // -------------------------------------------------------------
   // Instruction length and cycle figures
   // -------------------------------------------------------------
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;
   localparam logic [1:0] CYC_1 = 2'h1;
   localparam logic [1:0] CYC_2 = 2'h2;

   typedef enum logic [2:0] {
      SRC_NONE, SRC_ACC, SRC_BANK, SRC_DIR, SRC_IND, SRC_IMM
   } bmd_src_e;

   typedef enum logic [1:0] {
      DST_NONE, DST_ACC, DST_BANK, DST_DIR
   } bmd_dst_e;

endpackage

//--- hw/bmd_ram.sv
//----------------------------------------------------------------------
// Purpose: Internal data memory with one write and one read port
// Assumes: Single clock, read data registered
// Notes:   No reset; contents undefined until written
//----------------------------------------------------------------------
`timescale 1ns/1ps

module bmd_ram #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic mclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);

   // Elaboration check on geometry
   if (AW < 1 || AW > 16 || DW < 1) begin : g_chk
      $error("bmd_ram: unsupported geometry");
   end

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Write port
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read port
   always_ff @(posedge mclk) begin
      rdata <= mem[raddr];
   end

endmodule // bmd_ram

//--- hw/bmd_decode.sv
//----------------------------------------------------------------------
// Purpose: Decode and execute of byte moves between working register,
//          bank registers, direct and indirect locations, immediates
// Assumes: Whole instruction presented at once by the fetch unit
// Notes:   Reports documented length and cycle count per instruction
//----------------------------------------------------------------------
`timescale 1ns/1ps

// What this block does
// - Copy source operand value into destination location
// - Source, other registers and flags stay unchanged
// - Decode the supported source and destination pairings
// - Bank register from immediate, two bytes, one cycle
// - Direct from working register, two bytes, one cycle
// - Direct from bank register, two bytes, two cycles
// - Direct to direct, source then destination, three bytes
module bmd_decode (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] bank_sel,
   input wire logic ins_valid,
   input wire logic [7:0] ins_op,
   input wire logic [7:0] ins_b1,
   input wire logic [7:0] ins_b2,
   output logic ins_ready,
   output logic done,
   output logic illegal,
   output logic unknown,
   output logic [1:0] ins_bytes,
   output logic [1:0] ins_cycles,
   output logic [7:0] working_sum_register,
   output logic flags_we
);

   typedef enum logic [1:0] {S_IDLE, S_PTR, S_WR} bmd_state_e;

   // ------------------------------------------------------------
   // Decode functions
   // ------------------------------------------------------------
   function automatic logic [7:0] bank_addr(input logic [1:0] bk,
                                            input logic [2:0] r);
      return {3'h0, bk, r};
   endfunction

   function automatic bmd_pkg::bmd_src_e src_of(input logic [7:0] op);
      bmd_pkg::bmd_src_e s;
      s = bmd_pkg::SRC_NONE;
      if (op[7:3] == bmd_pkg::OP_A_BANK || op[7:3] == bmd_pkg::OP_DIR_BANK)
         s = bmd_pkg::SRC_BANK;
      else if (op[7:3] == bmd_pkg::OP_BANK_A || op == bmd_pkg::OP_DIR_A)
         s = bmd_pkg::SRC_ACC;
      else if (op[7:3] == bmd_pkg::OP_BANK_DIR || op == bmd_pkg::OP_A_DIR ||
               op == bmd_pkg::OP_DIR_DIR)
         s = bmd_pkg::SRC_DIR;
      else if (op[7:3] == bmd_pkg::OP_BANK_IMM || op == bmd_pkg::OP_A_IMM ||
               op == bmd_pkg::OP_DIR_IMM)
         s = bmd_pkg::SRC_IMM;
      else if (op[7:1] == bmd_pkg::OP_A_IND || op[7:1] == bmd_pkg::OP_DIR_IND)
         s = bmd_pkg::SRC_IND;
      return s;
   endfunction

   function automatic bmd_pkg::bmd_dst_e dst_of(input logic [7:0] op);
      bmd_pkg::bmd_dst_e d;
      d = bmd_pkg::DST_NONE;
      if (op[7:3] == bmd_pkg::OP_A_BANK || op == bmd_pkg::OP_A_DIR ||
          op[7:1] == bmd_pkg::OP_A_IND || op == bmd_pkg::OP_A_IMM)
         d = bmd_pkg::DST_ACC;
      else if (op[7:3] == bmd_pkg::OP_BANK_A ||
               op[7:3] == bmd_pkg::OP_BANK_DIR ||
               op[7:3] == bmd_pkg::OP_BANK_IMM)
         d = bmd_pkg::DST_BANK;
      else if (op == bmd_pkg::OP_DIR_A || op[7:3] == bmd_pkg::OP_DIR_BANK ||
               op == bmd_pkg::OP_DIR_DIR || op[7:1] == bmd_pkg::OP_DIR_IND ||
               op == bmd_pkg::OP_DIR_IMM)
         d = bmd_pkg::DST_DIR;
      return d;
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   bmd_state_e state_q, state_d;
   bmd_pkg::bmd_src_e src_d, src_q;
   bmd_pkg::bmd_dst_e dst_d, dst_q;
   logic [7:0] acc_q, imm_q, daddr_q, daddr_d, raddr, wdata, ram_rdata;
   logic accept, bad_acc, is_move, ram_we;
   logic [1:0] len_d, cyc_d;

   // ------------------------------------------------------------
   // Instruction classification at the accept edge
   // ------------------------------------------------------------
   always_comb begin
      src_d = src_of(ins_op);
      dst_d = dst_of(ins_op);
      is_move = (src_d != bmd_pkg::SRC_NONE);
      bad_acc = (ins_op == bmd_pkg::OP_A_DIR) &&
                (ins_b1 == bmd_pkg::ACC_DIR_ADDR);
      // Direct operand naming the working register is served from it
      if (src_d == bmd_pkg::SRC_DIR && ins_b1 == bmd_pkg::ACC_DIR_ADDR)
         src_d = bmd_pkg::SRC_ACC;
      daddr_d = (ins_op == bmd_pkg::OP_DIR_DIR) ? ins_b2 : ins_b1;
      if (dst_d == bmd_pkg::DST_BANK)
         daddr_d = bank_addr(bank_sel, ins_op[2:0]);
      else if (dst_d == bmd_pkg::DST_DIR &&
               daddr_d == bmd_pkg::ACC_DIR_ADDR)
         dst_d = bmd_pkg::DST_ACC;
      // Documented length and cycles
      len_d = bmd_pkg::LEN_2;
      if (ins_op[7:3] == bmd_pkg::OP_A_BANK ||
          ins_op[7:3] == bmd_pkg::OP_BANK_A ||
          ins_op[7:1] == bmd_pkg::OP_A_IND)
         len_d = bmd_pkg::LEN_1;
      else if (ins_op == bmd_pkg::OP_DIR_DIR || ins_op == bmd_pkg::OP_DIR_IMM)
         len_d = bmd_pkg::LEN_3;
      cyc_d = bmd_pkg::CYC_2;
      if (ins_op[7:3] == bmd_pkg::OP_A_BANK || ins_op == bmd_pkg::OP_A_DIR ||
          ins_op[7:1] == bmd_pkg::OP_A_IND || ins_op == bmd_pkg::OP_A_IMM ||
          ins_op[7:3] == bmd_pkg::OP_BANK_A ||
          ins_op[7:3] == bmd_pkg::OP_BANK_IMM ||
          ins_op == bmd_pkg::OP_DIR_A)
         cyc_d = bmd_pkg::CYC_1;
   end

   assign accept = ins_valid && ins_ready;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (accept && is_move && !bad_acc)
               state_d = (src_d == bmd_pkg::SRC_IND) ? S_PTR : S_WR;
         end
         S_PTR: state_d = S_WR;
         S_WR: state_d = S_IDLE;
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= S_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Latched operands of the accepted instruction
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         src_q <= bmd_pkg::SRC_NONE;
         dst_q <= bmd_pkg::DST_NONE;
         daddr_q <= 8'h00;
         imm_q <= 8'h00;
      end else if (accept) begin
         src_q <= src_d;
         dst_q <= dst_d;
         daddr_q <= daddr_d;
         imm_q <= (ins_op == bmd_pkg::OP_DIR_IMM) ? ins_b2 : ins_b1;
      end
   end

   // ------------------------------------------------------------
   // Memory read address and write data
   // ------------------------------------------------------------
   always_comb begin
      raddr = 8'h00;
      case (state_q)
         S_IDLE: begin
            if (src_d == bmd_pkg::SRC_BANK)
               raddr = bank_addr(bank_sel, ins_op[2:0]);
            else if (src_d == bmd_pkg::SRC_DIR)
               raddr = ins_b1;
            else if (src_d == bmd_pkg::SRC_IND)
               raddr = bank_addr(bank_sel, {2'h0, ins_op[0]});
         end
         S_PTR: raddr = ram_rdata;
         default: raddr = 8'h00;
      endcase
      if (src_q == bmd_pkg::SRC_ACC)
         wdata = acc_q;
      else if (src_q == bmd_pkg::SRC_IMM)
         wdata = imm_q;
      else
         wdata = ram_rdata;
   end

   assign ram_we = (state_q == S_WR) && (dst_q != bmd_pkg::DST_ACC);

   bmd_ram #(
      .AW(bmd_pkg::ADDR_W),
      .DW(bmd_pkg::DATA_W)
   ) u_ram (
      .mclk(mclk),
      .we(ram_we),
      .waddr(daddr_q),
      .wdata(wdata),
      .raddr(raddr),
      .rdata(ram_rdata)
   );

   // Working register; written only by moves that target it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         acc_q <= bmd_pkg::ACC_RESET;
      end else if (state_q == S_WR && dst_q == bmd_pkg::DST_ACC) begin
         acc_q <= wdata;
      end
   end

   // ------------------------------------------------------------
   // Status outputs
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ins_ready <= 1'b1;
         done <= 1'b0;
         illegal <= 1'b0;
         unknown <= 1'b0;
         flags_we <= 1'b0;
      end else begin
         ins_ready <= (state_d == S_IDLE);
         done <= (state_q == S_WR);
         illegal <= accept && bad_acc;
         unknown <= accept && !is_move;
         flags_we <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ins_bytes <= 2'h0;
         ins_cycles <= 2'h0;
      end else if (accept && is_move) begin
         ins_bytes <= len_d;
         ins_cycles <= cyc_d;
      end
   end

   assign working_sum_register = acc_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_acc_imm;
      @(posedge mclk) disable iff (rst)
      accept && ins_op == bmd_pkg::OP_A_IMM |->
         ##2 working_sum_register == $past(ins_b1, 2);
   endproperty
   a_acc_imm: assert property (p_acc_imm)
      else $error("working register not loaded with immediate");

   property p_no_flags;
      @(posedge mclk) disable iff (rst)
      state_q != S_WR |=> $stable(working_sum_register) && !flags_we;
   endproperty
   a_no_flags: assert property (p_no_flags)
      else $error("flag write or stray working register change");

   property p_unknown;
      @(posedge mclk) disable iff (rst)
      accept && !is_move |=> unknown && ins_ready ##1 !done;
   endproperty
   a_unknown: assert property (p_unknown)
      else $error("non-move opcode not refused");

   property p_illegal;
      @(posedge mclk) disable iff (rst)
      accept && bad_acc |=> illegal && ins_ready && !done;
   endproperty
   a_illegal: assert property (p_illegal)
      else $error("illegal self move executed");

   property p_bank_imm;
      @(posedge mclk) disable iff (rst)
      accept && ins_op[7:3] == bmd_pkg::OP_BANK_IMM |=>
         ins_bytes == 2'h2 && ins_cycles == 2'h1 ##1 done && ram_we == 1'b0;
   endproperty
   a_bank_imm: assert property (p_bank_imm)
      else $error("bank immediate length or cycles wrong");

   property p_dir_acc;
      @(posedge mclk) disable iff (rst)
      accept && ins_op == bmd_pkg::OP_DIR_A && ins_b1 != 8'he0 |->
         ##1 (ram_we && wdata == working_sum_register && ins_bytes == 2'h2);
   endproperty
   a_dir_acc: assert property (p_dir_acc)
      else $error("direct store of working register wrong");

   property p_dir_bank;
      @(posedge mclk) disable iff (rst)
      accept && ins_op[7:3] == bmd_pkg::OP_DIR_BANK |=>
         ins_cycles == 2'h2 && ins_bytes == 2'h2;
   endproperty
   a_dir_bank: assert property (p_dir_bank)
      else $error("direct from bank cycles wrong");

   property p_dir_dir;
      @(posedge mclk) disable iff (rst)
      accept && ins_op == bmd_pkg::OP_DIR_DIR && ins_b2 != 8'he0 |->
         ##1 ram_we && u_ram.waddr == $past(ins_b2) && ins_bytes == 2'h3;
   endproperty
   a_dir_dir: assert property (p_dir_dir)
      else $error("direct to direct destination wrong");

   property p_a_bank;
      @(posedge mclk) disable iff (rst)
      accept && ins_op[7:3] == bmd_pkg::OP_A_BANK |=>
         ins_bytes == 2'h1 && ins_cycles == 2'h1 ##1 done && ins_ready;
   endproperty
   a_a_bank: assert property (p_a_bank)
      else $error("working register from bank timing wrong");

   property p_a_ind;
      @(posedge mclk) disable iff (rst)
      accept && ins_op[7:1] == bmd_pkg::OP_A_IND |->
         ##1 !ins_ready ##1 !done ##1 done;
   endproperty
   a_a_ind: assert property (p_a_ind)
      else $error("indirect load sequence wrong");

   c_dir_dir: cover property (@(posedge mclk) disable iff (rst)
      accept && ins_op == bmd_pkg::OP_DIR_DIR ##2 done);
   c_ind: cover property (@(posedge mclk) disable iff (rst)
      accept && ins_op[7:1] == bmd_pkg::OP_A_IND ##3 done);
   c_illegal: cover property (@(posedge mclk) disable iff (rst) illegal);

endmodule // bmd_decode

//--- sim/bmd_fetch_model.sv
//----------------------------------------------------------------------
// Purpose: Fetch unit model offering whole instructions to the decoder
// Assumes: One clock; request held until ready is sampled high
// Notes:   Idle byte lanes show the inverted last value, never stale data
//----------------------------------------------------------------------
`timescale 1ns/1ps

module bmd_fetch_model (
   input wire logic mclk,
   input wire logic ins_ready,
   output logic ins_valid,
   output logic [7:0] ins_op,
   output logic [7:0] ins_b1,
   output logic [7:0] ins_b2
);
   // Idle lanes at time zero
   initial begin
      ins_valid = 1'b0;
      ins_op = 8'h00;
      ins_b1 = 8'h00;
      ins_b2 = 8'h00;
   end

   // Offer one instruction after a gap, hold it until taken
   task automatic issue(input logic [7:0] op, input logic [7:0] b1,
                        input logic [7:0] b2, input int gap,
                        output bit to);
      int k;
      repeat (gap + 1) @(posedge mclk);
      ins_valid <= 1'b1;
      ins_op <= op;
      ins_b1 <= b1;
      ins_b2 <= b2;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (ins_ready !== 1'b1 && k < 20);
      to = (ins_ready !== 1'b1);
      ins_valid <= 1'b0;
      ins_op <= ~op;
      ins_b1 <= ~b1;
      ins_b2 <= ~b2;
   endtask
endmodule // bmd_fetch_model

//--- sim/byte_move_instruction_decode_bench.sv
//----------------------------------------------------------------------
// Purpose: Self-checking bench for the byte-move decode block
// Assumes: Fetch model offers whole instructions; RAM mirrored here
// Notes:   Internal RAM is seen by reading it back into the working reg
//----------------------------------------------------------------------
`timescale 1ns/1ps

module byte_move_instruction_decode_bench;
   logic mclk, rst, ins_valid, ins_ready, done, illegal, unknown, flags_we;
   logic [1:0] bank_sel, ins_bytes, ins_cycles;
   logic [7:0] ins_op, ins_b1, ins_b2, working_sum_register, acc_m, op;
   logic [7:0] ram_m [0:255];
   logic [7:0] ops [0:11];
   logic [31:0] rv;
   int error_cnt, n_tests, seed, i;

   bmd_decode u_bmd_decode (.mclk(mclk), .rst(rst), .bank_sel(bank_sel),
      .ins_valid(ins_valid), .ins_op(ins_op), .ins_b1(ins_b1),
      .ins_b2(ins_b2), .ins_ready(ins_ready), .done(done),
      .illegal(illegal), .unknown(unknown), .ins_bytes(ins_bytes),
      .ins_cycles(ins_cycles), .working_sum_register(working_sum_register),
      .flags_we(flags_we));

   bmd_fetch_model u_bmd_fetch_model (.mclk(mclk), .ins_ready(ins_ready),
      .ins_valid(ins_valid), .ins_op(ins_op), .ins_b1(ins_b1),
      .ins_b2(ins_b2));

   // Clock
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Counts, verdict, end of run
   task automatic stop_test();
      $display("Compares %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Reference read and write of a direct location
   function automatic logic [7:0] rd(input logic [7:0] a);
      return (a == bmd_pkg::ACC_DIR_ADDR) ? acc_m : ram_m[a];
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      if (a == bmd_pkg::ACC_DIR_ADDR)
         acc_m = v;
      else
         ram_m[a] = v;
   endtask

   // Documented length and cycles, zero where not fixed
   function automatic logic [3:0] doc_fig(input logic [7:0] o);
      casez (o)
         8'b11101???, 8'he6, 8'he7, 8'b11111???:
            return {bmd_pkg::LEN_1, bmd_pkg::CYC_1};
         8'he5, 8'h74, 8'b01111???, 8'hf5:
            return {bmd_pkg::LEN_2, bmd_pkg::CYC_1};
         8'b10001???, 8'h86, 8'h87:
            return {bmd_pkg::LEN_2, bmd_pkg::CYC_2};
         8'h75: return {bmd_pkg::LEN_3, bmd_pkg::CYC_2};
         8'h85: return {bmd_pkg::LEN_3, 2'h0};
         default: return 4'h0;
      endcase
   endfunction

   // Reference effect; kind 0 move, 1 refused, 2 not a move
   task automatic model(input logic [7:0] o, input logic [7:0] b1,
                        input logic [7:0] b2, output int kind);
      logic [7:0] bk, pt;
      bk = {3'b000, bank_sel, o[2:0]};
      pt = {3'b000, bank_sel, 2'b00, o[0]};
      kind = 0;
      casez (o)
         8'b11101???: acc_m = rd(bk);
         8'he5: begin
            if (b1 == bmd_pkg::ACC_DIR_ADDR)
               kind = 1;
            else
               acc_m = rd(b1);
         end
         8'he6, 8'he7: acc_m = ram_m[ram_m[pt]];
         8'h74: acc_m = b1;
         8'b11111???: wr(bk, acc_m);
         8'b10101???: wr(bk, rd(b1));
         8'b01111???: wr(bk, b1);
         8'hf5: wr(b1, acc_m);
         8'b10001???: wr(b1, rd(bk));
         8'h85: wr(b2, rd(b1));
         8'h86, 8'h87: wr(b1, ram_m[ram_m[pt]]);
         8'h75: wr(b1, b2);
         default: kind = 2;
      endcase
   endtask

   // Issue one instruction and check its whole answer
   task automatic run(input logic [7:0] o, input logic [7:0] b1,
                      input logic [7:0] b2);
      int kind, n, lat;
      bit to;
      logic [3:0] fig;
      logic [2:0] flg;
      fig = doc_fig(o);
      lat = (o[7:1] == bmd_pkg::OP_A_IND || o[7:1] == bmd_pkg::OP_DIR_IND)
            ? 3 : 2;
      u_bmd_fetch_model.issue(o, b1, b2, $unsigned($random(seed)) % 3, to);
      if (to) begin
         error_cnt++;
         stop_test();
      end
      model(o, b1, b2, kind);
      if (kind != 0)
         lat = 1;
      // First look just after the accept edge, then once per edge
      for (n = 1; n <= 6; n++) begin
         #1;
         check({7'h0, flags_we}, 8'h00);
         if (n == 1) begin
            check({7'h0, ins_ready}, {7'h0, kind != 0});
            if (kind == 0 && fig[3:2] != 2'h0) begin
               check({6'h0, ins_bytes}, {6'h0, fig[3:2]});
            end
            if (kind == 0 && fig[1:0] != 2'h0) begin
               check({6'h0, ins_cycles}, {6'h0, fig[1:0]});
            end
         end
         flg = {done, illegal, unknown};
         if (flg !== 3'b000)
            break;
         @(posedge mclk);
      end
      if (n > 6) begin
         error_cnt++;
         stop_test();
      end
      check(n[7:0], lat[7:0]);
      check({5'h0, flg}, 8'h04 >> kind);
      check({7'h0, ins_ready}, 8'h01);
      check(working_sum_register, acc_m);
   endtask

   // Main sequence
   initial begin
      seed = 32'h02f5;
      error_cnt = 0;
      n_tests = 0;
      rst = 1'b1;
      bank_sel = 2'h0;
      acc_m = bmd_pkg::ACC_RESET;
      ops = '{8'he8, 8'he5, 8'he6, 8'h74, 8'hf8, 8'ha8, 8'h78, 8'hf5,
              8'h88, 8'h85, 8'h86, 8'h75};
      @(posedge mclk);
      #1;
      check({ins_ready, done, illegal, unknown, flags_we, 3'h0}, 8'h80);
      check({ins_bytes, ins_cycles, 4'h0}, 8'h00);
      check(working_sum_register, bmd_pkg::ACC_RESET);
      @(posedge mclk);
      rst <= 1'b0;
      $display("Test reset done");
      // Known byte in every direct location
      for (i = 0; i < 256; i++) begin
         rv = $random(seed);
         run(8'h75, i[7:0], rv[7:0]);
      end
      $display("Test fill done");
      // Corner cases
      run(8'h85, 8'h40, 8'h40);
      run(8'h85, 8'h41, 8'he0);
      run(8'h85, 8'he0, 8'h42);
      run(8'hf5, 8'he0, 8'h5a);
      run(8'he5, 8'he0, 8'h00);
      run(8'h00, 8'h11, 8'h22);
      run(8'hf6, 8'h11, 8'h22);
      run(8'h76, 8'h33, 8'h44);
      run(8'ha5, 8'h55, 8'h66);
      $display("Test corners done");
      // Random moves over all supported forms and banks
      for (i = 0; i < 300; i++) begin
         rv = $random(seed);
         op = ops[rv[31:24] % 8'd12];
         if (op[3])
            op[2:0] = rv[2:0];
         else if (op[2:1] == 2'b11)
            op[0] = rv[0];
         if (op == 8'he5 && rv[15:8] == 8'he0)
            rv[15:8] = 8'h30;
         if ((op[7:1] == bmd_pkg::OP_A_IND || op[7:1] == bmd_pkg::OP_DIR_IND)
             && ram_m[{3'b000, rv[23:22], 2'b00, op[0]}] == 8'he0)
            op = 8'h74;
         @(posedge mclk);
         bank_sel <= rv[23:22];
         run(op, rv[15:8], rv[7:0]);
      end
      $display("Test random done");
      // Reset in mid-run clears the working register, but not the RAM
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      #1;
      check(working_sum_register, bmd_pkg::ACC_RESET);
      @(posedge mclk);
      rst <= 1'b0;
      acc_m = bmd_pkg::ACC_RESET;
      // Read back every location except 8'he0 into the working register
      for (i = 0; i < 256; i++) begin
         if (i[7:0] != bmd_pkg::ACC_DIR_ADDR)
            run(8'he5, i[7:0], 8'h00);
      end
      $display("Test readback done");
      stop_test();
   end
endmodule // byte_move_instruction_decode_bench
